/* File: design/serial_port_pkg.sv */
// Shared constants and carriers for the serial port block
`default_nettype none
package serial_port_pkg;
	// Special function register addresses
	localparam logic [7:0] ADDR_SERIAL_PORT_CONTROL = 8'hf8;
	localparam logic [7:0] ADDR_SERIAL_PORT_DATA    = 8'hf7;
	localparam logic [7:0] ADDR_TWOWIRE_CONTROL     = 8'he8;
	localparam logic [7:0] ADDR_TWOWIRE_STATUS      = 8'he9;
	// Reset values
	localparam logic [7:0] RST_SERIAL_PORT_CONTROL = 8'h04;
	localparam logic [7:0] RST_SERIAL_PORT_DATA    = 8'h00;
	localparam logic [7:0] RST_TWOWIRE_CONTROL     = 8'h00;
	// Serial port control fields
	localparam int SPC_DONE   = 7;
	localparam int SPC_WRITE_COLLISION_FLAG   = 6;
	localparam int SPC_ENABLE = 5;
	localparam int SPC_MASTER = 4;
	localparam int SPC_CPOL   = 3;
	localparam int SPC_CPHA   = 2;
	localparam int SPC_RATE_HI = 1;
	localparam int SPC_RATE_LO = 0;
	// Two-wire control fields
	localparam int TWC_MDO  = 7;
	localparam int TWC_MDE  = 6;
	localparam int TWC_MCO  = 5;
	localparam int TWC_MDI  = 4;
	localparam int TWC_MSEL = 3;
	localparam int TWC_GC   = 6;
	localparam int TWC_ID_LO = 4;
	// Byte geometry
	localparam int BYTE_BITS = 8;
	localparam logic [3:0] BIT_COUNT_LAST = 4'h7;
	// Divide ratio per rate code is 2 << code, half period 1 << code
	localparam logic [3:0] HALF_PERIOD_BASE = 4'h1;

	typedef enum logic [1:0] {
		IRQ_START_MATCH  = 2'h0,
		IRQ_RESTART_MATCH = 2'h1,
		IRQ_USER_DATA    = 2'h2,
		IRQ_STOP_AFTER   = 2'h3
	} twowire_irq_code_e;

	// Register access carrier
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic       bit_wr;
		logic [2:0] bit_idx;
		logic       bit_val;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_s;

	// Events from the hardware two-wire slave engine
	typedef struct packed {
		logic             general_call;
		logic             irq_valid;
		twowire_irq_code_e irq_code;
		logic             stop_seen;
	} twowire_slave_evt_s;
endpackage
`default_nettype wire

/* File: design/serial_port.sv */
// Shared byte-wide serial engine and two-wire software master port
// Functional notes
// - Master drives clock out and emits exactly eight clocks per data write.
// - Master clock rate comes from the two rate-select bits.
// - Slave-select input is ignored in master mode.
// - Master shifts one bit out and samples one bit in per clock.
// - After eighth master clock: done flag, interrupt, received byte latched.
// - Slave: data write loads byte; each clock shifts out and captures in.
// - Slave: done flag, interrupt and data update only after full byte.
// - Slave byte ends after eighth clock if phase 1, select high if 0.
// - Two-wire pins shared with data and clock, usable when engine off or moved.
// - Two-wire slave in hardware; master only by software pin control.
// - Control bit 7 drives data pin when drive-enable set.
// - Control bit 6 makes data pin output when set, input when clear.
// - Control bit 5 sets clock pin level directly.
// - Bit 4 latches data pin on clock rising edge while drive-enable is 0.
// - Bit 3 selects software master (1) or hardware slave (0), always visible.
// - Slave: bit 7 enables stop interrupts after a valid start.
// - Slave: bit 6 set by general call, held until software clears.
// - Slave: bits 5:4 give the interrupt cause code.
// - Two-wire control resets to zero and is bit-addressable.
// - Reading data register or direct clear drops the done flag.
// - Data write during a transfer sets write collision; software clears it.
// - Data write supplies transmit byte; read returns last received byte.
`default_nettype none
module serial_port #(
	parameter int DATA_BITS = 8
) (
	input  wire logic                                   clk_sys,
	input  wire logic                                   rst,
	input  wire logic                                   clk_link,
	input  wire serial_port_pkg::sfr_req_s              sfr_req,
	output logic [7:0]                                  sfr_rdata,
	output logic                                        irq_serial,
	input  wire serial_port_pkg::twowire_slave_evt_s    twowire_evt,
	input  wire logic                                   pin_relocate_bit,
	input  wire logic                                   ss_n_in,
	input  wire logic                                   serial_clock_pin_in,
	output logic                                        serial_clock_pin_out,
	output logic                                        serial_clock_pin_oe,
	input  wire logic                                   serial_data_pin_in,
	output logic                                        serial_data_pin_out,
	output logic                                        serial_data_pin_oe,
	input  wire logic                                   miso_in,
	output logic                                        miso_out,
	output logic                                        miso_oe
);
	initial
	begin
		if (DATA_BITS != serial_port_pkg::BYTE_BITS)
			$error("serial_port serves only byte-wide transfers");
	end

	logic [7:0] spc_q, spc_d;
	logic [7:0] rx_data_q, rx_data_d;
	logic [7:0] twc_q, twc_d;
	logic [7:0] shift_q, shift_d;
	logic [3:0] bit_cnt_q, bit_cnt_d;
	logic [3:0] div_cnt_q, div_cnt_d;
	logic       sclk_q, sclk_d;
	logic       busy_q, busy_d;
	logic       mosi_q, mosi_d;
	logic [1:0] m_smp_q, m_end_q;
	logic [7:0] m_rx_q;

	typedef enum logic [1:0] {M_IDLE, M_LEAD, M_TRAIL} master_state_e;
	master_state_e mst_q, mst_d;

	wire       acc_wr     = sfr_req.wr;
	wire       acc_bwr    = sfr_req.bit_wr;
	wire       hit_spc    = sfr_req.addr == serial_port_pkg::ADDR_SERIAL_PORT_CONTROL;
	wire       hit_dat    = sfr_req.addr == serial_port_pkg::ADDR_SERIAL_PORT_DATA;
	wire       hit_twc    = sfr_req.addr == serial_port_pkg::ADDR_TWOWIRE_CONTROL;
	wire       dat_write  = acc_wr && hit_dat;
	wire       dat_read   = sfr_req.rd && hit_dat;
	wire       enabled    = spc_q[serial_port_pkg::SPC_ENABLE];
	wire       is_master  = spc_q[serial_port_pkg::SPC_MASTER];
	wire       cpol       = spc_q[serial_port_pkg::SPC_CPOL];
	wire       cpha       = spc_q[serial_port_pkg::SPC_CPHA];
	wire [1:0] rate_code  = {spc_q[serial_port_pkg::SPC_RATE_HI], spc_q[serial_port_pkg::SPC_RATE_LO]};
	wire       tw_master  = twc_q[serial_port_pkg::TWC_MSEL];

	logic [1:0] ss_sync_q, miso_sync_q, sda_sync_q, scl_sync_q;
	always_ff @(posedge clk_sys)
	begin
		ss_sync_q   <= {ss_sync_q[0], ss_n_in};
		miso_sync_q <= {miso_sync_q[0], miso_in};
		sda_sync_q  <= {sda_sync_q[0], serial_data_pin_in};
		scl_sync_q  <= {scl_sync_q[0], serial_clock_pin_in};
	end
	wire ss_n_s = ss_sync_q[1];
	wire miso_s = miso_sync_q[1];
	wire sda_s  = sda_sync_q[1];
	wire scl_s  = scl_sync_q[1];
	logic scl_prev_q;
	always_ff @(posedge clk_sys)
		scl_prev_q <= rst ? 1'b0 : scl_s;

	// Link-side copies of configuration, sampled through two flops
	logic [1:0] cfg_cpol_q, cfg_cpha_q, cfg_act_q;
	wire slave_active = enabled && !is_master;
	always_ff @(posedge clk_link)
	begin
		cfg_cpol_q <= {cfg_cpol_q[0], cpol};
		cfg_cpha_q <= {cfg_cpha_q[0], cpha};
		cfg_act_q  <= {cfg_act_q[0], slave_active};
	end
	// Slave load: toggle from sys domain carries the transmit byte
	logic       load_tgl_q;
	logic [7:0] tx_hold_q;
	logic [2:0] load_sync_q;
	logic [7:0] sl_shift_q;
	logic [2:0] sl_cnt_q;
	logic       sl_done_tgl_q;
	logic [7:0] sl_rx_q;
	logic       sl_cnt_full_q;
	// Link domain sees clock and select already sampled by the link clock
	logic [1:0] lk_scl_q, lk_ss_q, lk_mosi_q;
	logic       lk_scl_prev_q;
	always_ff @(posedge clk_link)
	begin
		lk_scl_q  <= {lk_scl_q[0], serial_clock_pin_in};
		lk_ss_q   <= {lk_ss_q[0], ss_n_in};
		lk_mosi_q <= {lk_mosi_q[0], serial_data_pin_in};
		lk_scl_prev_q <= lk_scl_q[1];
	end
	wire lk_cpol   = cfg_cpol_q[1];
	wire lk_cpha   = cfg_cpha_q[1];
	wire lk_leave  = lk_scl_q[1] != lk_scl_prev_q && (lk_scl_q[1] ^ lk_cpol);
	wire lk_trail  = lk_scl_q[1] != lk_scl_prev_q && !(lk_scl_q[1] ^ lk_cpol);
	wire lk_sample = lk_cpha ? lk_trail : lk_leave;
	wire lk_shift  = lk_cpha ? lk_leave : lk_trail;
	wire lk_sel    = !lk_ss_q[1] && cfg_act_q[1];
	logic       lk_ss_prev_q;
	always_ff @(posedge clk_link)
	begin
		load_sync_q  <= {load_sync_q[1:0], load_tgl_q};
		lk_ss_prev_q <= lk_ss_q[1];
		if (rst)
		begin
			sl_shift_q    <= serial_port_pkg::RST_SERIAL_PORT_DATA;
			sl_cnt_q      <= '0;
			sl_done_tgl_q <= 1'b0;
			sl_rx_q       <= serial_port_pkg::RST_SERIAL_PORT_DATA;
			sl_cnt_full_q <= 1'b0;
		end
		else
		begin
			if (load_sync_q[2] != load_sync_q[1])
			begin
				sl_shift_q    <= tx_hold_q;
				sl_cnt_q      <= '0;
				sl_cnt_full_q <= 1'b0;
			end
			else if (lk_sel && lk_sample)
			begin
				sl_cnt_q    <= sl_cnt_q + 3'h1;
				// Phase 1 ends at eighth clock
				if (sl_cnt_q == serial_port_pkg::BIT_COUNT_LAST[2:0])
				begin
					sl_cnt_full_q <= 1'b1;
					if (lk_cpha)
					begin
						sl_rx_q       <= {sl_shift_q[6:0], lk_mosi_q[1]};
						sl_done_tgl_q <= ~sl_done_tgl_q;
					end
				end
				sl_shift_q <= {sl_shift_q[6:0], lk_mosi_q[1]};
			end
			else if (lk_sel && lk_shift)
				sl_shift_q <= sl_shift_q;
			// Phase 0 ends when select rises
			if (!lk_cpha && sl_cnt_full_q && lk_ss_q[1] && !lk_ss_prev_q)
			begin
				sl_rx_q       <= sl_shift_q;
				sl_done_tgl_q <= ~sl_done_tgl_q;
				sl_cnt_full_q <= 1'b0;
			end
		end
	end

	// Done toggle back into the core domain
	logic [2:0] done_sync_q;
	always_ff @(posedge clk_sys)
		done_sync_q <= rst ? 3'h0 : {done_sync_q[1:0], sl_done_tgl_q};
	wire slave_done = done_sync_q[2] != done_sync_q[1];

	wire [3:0] half_period = serial_port_pkg::HALF_PERIOD_BASE << rate_code;
	wire       div_tick    = div_cnt_q == half_period - 4'h1;
	wire       m_start     = dat_write && enabled && is_master && !busy_q;
	logic      m_done;
	wire       m_smp       = div_tick && ((mst_q == M_LEAD && !cpha) || (mst_q == M_TRAIL && cpha));
	always_comb
	begin
		mst_d     = mst_q;
		mosi_d    = mosi_q;
		div_cnt_d = div_tick ? 4'h0 : div_cnt_q + 4'h1;
		bit_cnt_d = bit_cnt_q;
		sclk_d    = sclk_q;
		shift_d   = shift_q;
		m_done    = 1'b0;
		case (mst_q)
			M_IDLE:
			begin
				sclk_d    = cpol;
				div_cnt_d = 4'h0;
				if (m_start)
				begin
					shift_d   = cpha ? sfr_req.wdata : {sfr_req.wdata[6:0], 1'b0};
					mosi_d    = sfr_req.wdata[7];
					bit_cnt_d = 4'h0;
					mst_d     = M_LEAD;
				end
			end
			M_LEAD:
			begin
				if (div_tick)
				begin
					sclk_d = ~cpol;
					mst_d  = M_TRAIL;
					// Phase 1 launches on leading edge
					if (cpha)
					begin
						mosi_d  = shift_q[7];
						shift_d = {shift_q[6:0], 1'b0};
					end
				end
			end
			M_TRAIL:
			begin
				if (div_tick)
				begin
					sclk_d = cpol;
					// Phase 0 launches on trailing edge
					if (!cpha)
					begin
						mosi_d  = shift_q[7];
						shift_d = {shift_q[6:0], 1'b0};
					end
					if (bit_cnt_q == serial_port_pkg::BIT_COUNT_LAST)
					begin
						m_done = 1'b1;
						mst_d  = M_IDLE;
					end
					else
					begin
						bit_cnt_d = bit_cnt_q + 4'h1;
						mst_d     = M_LEAD;
					end
				end
			end
			default:
				mst_d = M_IDLE;
		endcase
	end
	// Miso sample and end delayed to match the two-flop synchroniser
	wire [7:0] m_rx_next = m_smp_q[1] ? {m_rx_q[6:0], miso_s} : m_rx_q;
	wire       m_fin     = m_end_q[1];

	wire write_collision_flag_set = dat_write && busy_q;
	wire done_set = m_fin || slave_done;
	always_comb
	begin
		spc_d = spc_q;
		if (acc_wr && hit_spc)
			spc_d = sfr_req.wdata;
		else if (acc_bwr && hit_spc)
			spc_d[sfr_req.bit_idx] = sfr_req.bit_val;
		if (dat_read)
			spc_d[serial_port_pkg::SPC_DONE] = 1'b0;
		if (done_set)
			spc_d[serial_port_pkg::SPC_DONE] = 1'b1;
		if (write_collision_flag_set)
			spc_d[serial_port_pkg::SPC_WRITE_COLLISION_FLAG] = 1'b1;
		rx_data_d = rx_data_q;
		if (m_fin)
			rx_data_d = m_rx_next;
		else if (slave_done)
			rx_data_d = sl_rx_q;
	end
	wire slave_busy = enabled && !is_master && !ss_n_s;
	assign busy_d = (mst_d != M_IDLE) || m_done || m_end_q[0] || slave_busy;

	// Two-wire control register
	wire scl_rise = scl_s && !scl_prev_q;
	always_comb
	begin
		twc_d = twc_q;
		if (acc_wr && hit_twc)
			twc_d = sfr_req.wdata;
		else if (acc_bwr && hit_twc)
			twc_d[sfr_req.bit_idx] = sfr_req.bit_val;
		if (tw_master)
		begin
			// Latch data pin on clock rise
			if (scl_rise && !twc_q[serial_port_pkg::TWC_MDE])
				twc_d[serial_port_pkg::TWC_MDI] = sda_s;
		end
		else
		begin
			if (twowire_evt.general_call)
				twc_d[serial_port_pkg::TWC_GC] = 1'b1;
			// Cause code; stop gated by enable
			if (twowire_evt.irq_valid)
				twc_d[serial_port_pkg::TWC_ID_LO +: 2] = twowire_evt.irq_code;
			else if (twowire_evt.stop_seen && twc_q[serial_port_pkg::TWC_MDO])
				twc_d[serial_port_pkg::TWC_ID_LO +: 2] = serial_port_pkg::IRQ_STOP_AFTER;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			spc_q     <= serial_port_pkg::RST_SERIAL_PORT_CONTROL;
			rx_data_q <= serial_port_pkg::RST_SERIAL_PORT_DATA;
			twc_q     <= serial_port_pkg::RST_TWOWIRE_CONTROL;
			shift_q   <= serial_port_pkg::RST_SERIAL_PORT_DATA;
			bit_cnt_q <= 4'h0;
			div_cnt_q <= 4'h0;
			sclk_q    <= 1'b0;
			busy_q    <= 1'b0;
			mst_q     <= M_IDLE;
			load_tgl_q <= 1'b0;
			tx_hold_q <= serial_port_pkg::RST_SERIAL_PORT_DATA;
			mosi_q    <= 1'b0;
			m_smp_q   <= 2'h0;
			m_end_q   <= 2'h0;
			m_rx_q    <= serial_port_pkg::RST_SERIAL_PORT_DATA;
		end
		else
		begin
			spc_q     <= spc_d;
			rx_data_q <= rx_data_d;
			twc_q     <= twc_d;
			shift_q   <= shift_d;
			bit_cnt_q <= bit_cnt_d;
			div_cnt_q <= div_cnt_d;
			sclk_q    <= sclk_d;
			busy_q    <= busy_d;
			mst_q     <= mst_d;
			mosi_q    <= mosi_d;
			m_smp_q   <= {m_smp_q[0], m_smp};
			m_end_q   <= {m_end_q[0], m_done};
			m_rx_q    <= m_rx_next;
			// Slave load handed to link domain
			if (dat_write && enabled && !is_master && !busy_q)
			begin
				tx_hold_q  <= sfr_req.wdata;
				load_tgl_q <= ~load_tgl_q;
			end
		end
	end

	// Stop interrupt enable shares bit 7 in slave mode
	wire tw_stop_irq = !tw_master && twowire_evt.stop_seen && twc_q[serial_port_pkg::TWC_MDO];
	assign irq_serial = spc_q[serial_port_pkg::SPC_DONE] || tw_stop_irq
		|| (!tw_master && twowire_evt.irq_valid);

	// Read mux; in slave mode rate bit 0 shows the select pin
	wire [7:0] spc_view = is_master ? spc_q : {spc_q[7:1], ss_n_s};
	assign sfr_rdata = hit_spc ? spc_view
		: hit_dat ? rx_data_q
		: hit_twc ? twc_q
		: 8'h00;

	// Two-wire owns pins when engine off or relocated
	wire tw_owns = !enabled || pin_relocate_bit;
	wire spi_m = enabled && is_master && !pin_relocate_bit;
	always_comb
	begin
		serial_clock_pin_out = 1'b0;
		serial_clock_pin_oe  = 1'b0;
		serial_data_pin_out  = 1'b0;
		serial_data_pin_oe   = 1'b0;
		if (spi_m)
		begin
			serial_clock_pin_out = sclk_q;
			serial_clock_pin_oe  = 1'b1;
			serial_data_pin_out  = mosi_q;
			serial_data_pin_oe   = 1'b1;
		end
		else if (tw_owns && tw_master)
		begin
			serial_clock_pin_out = twc_q[serial_port_pkg::TWC_MCO];
			serial_clock_pin_oe  = 1'b1;
			serial_data_pin_out  = twc_q[serial_port_pkg::TWC_MDO];
			serial_data_pin_oe   = twc_q[serial_port_pkg::TWC_MDE];
		end
	end
	assign miso_out = sl_shift_q[7];
	assign miso_oe  = slave_active && !ss_n_s;

	logic [3:0] edge_cnt_q;
	logic [4:0] gap_q;
	always_ff @(posedge clk_sys)
		edge_cnt_q <= (rst || m_start) ? 4'h0 : (m_done ? edge_cnt_q : edge_cnt_q + {3'h0, div_tick && mst_q == M_TRAIL});
	always_ff @(posedge clk_sys)
		gap_q <= (rst || sclk_d != sclk_q) ? 5'h00 : gap_q + 5'h01;

	a_burst_eight_clocks: assert property (@(posedge clk_sys) disable iff (rst)
		m_done |-> bit_cnt_q == serial_port_pkg::BIT_COUNT_LAST) else $error("burst not eight clocks");
	a_rate_divider: assert property (@(posedge clk_sys) disable iff (rst)
		(mst_q == M_TRAIL && div_tick) |-> gap_q == (5'h01 << rate_code) - 5'h01) else $error("bad divide");
	a_eight_trail_edges: assert property (@(posedge clk_sys) disable iff (rst)
		m_done |-> edge_cnt_q == 4'h7) else $error("trail edge count");
	a_done_sets_flag: assert property (@(posedge clk_sys) disable iff (rst)
		m_fin |=> spc_q[serial_port_pkg::SPC_DONE] && rx_data_q == $past(m_rx_next)) else $error("done not set");
	a_read_clears: assert property (@(posedge clk_sys) disable iff (rst)
		(dat_read && !done_set && !(hit_spc)) |=> !spc_q[serial_port_pkg::SPC_DONE]) else $error("read no clear");
	a_collision_flag: assert property (@(posedge clk_sys) disable iff (rst)
		(dat_write && busy_q) |=> spc_q[serial_port_pkg::SPC_WRITE_COLLISION_FLAG]) else $error("collision missed");
	a_master_clock_oe: assert property (@(posedge clk_sys) disable iff (rst)
		(tw_owns && tw_master && !spi_m) |-> serial_clock_pin_oe
			&& serial_clock_pin_out == twc_q[serial_port_pkg::TWC_MCO]) else $error("clock bit");
	a_data_drive_bit: assert property (@(posedge clk_sys) disable iff (rst)
		(tw_owns && tw_master && !spi_m) |-> serial_data_pin_oe == twc_q[serial_port_pkg::TWC_MDE]) else $error("mde");
	a_gc_sticky: assert property (@(posedge clk_sys) disable iff (rst)
		(!tw_master && twowire_evt.general_call) |=> twc_q[serial_port_pkg::TWC_GC]) else $error("gc lost");
	a_burst_idle_start: assert property (@(posedge clk_sys) disable iff (rst)
		m_start |=> mst_q == M_LEAD ##0 sclk_q == cpol) else $error("no burst");
	c_master_byte: cover property (@(posedge clk_sys) disable iff (rst) m_done);
	c_slave_byte: cover property (@(posedge clk_sys) disable iff (rst) slave_done);
	c_collision: cover property (@(posedge clk_sys) disable iff (rst) write_collision_flag_set);
endmodule
`default_nettype wire

/* File: verification/spi_far_end.sv */
// Far-end serial device model: slave or master
`default_nettype none
module spi_far_end (
	input  wire logic clk_link,
	input  wire logic sclk_in,
	input  wire logic mosi_in,
	input  wire logic miso_in,
	output logic      sclk_out,
	output logic      mosi_out,
	output logic      ss_n,
	output logic      miso_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] sh;
	logic [7:0] rx_byte;
	initial
	begin
		{sclk_out, mosi_out, ss_n, miso_out, sh, rx_byte} = {4'h2, 16'h0000};
	end
	task automatic load(input logic [7:0] b);
		sh = b;
	endtask
	always @(posedge sclk_in)
		if (ss_n)
			miso_out <= sh[7];
	always @(negedge sclk_in)
		if (ss_n)
		begin
			sh <= {sh[6:0], mosi_in};
			rx_byte <= {sh[6:0], mosi_in};
		end
	task automatic run_master(input logic [7:0] b);
		sh = b;
		ss_n = 1'b0;
		repeat (4) @(negedge clk_link);
		for (int i = 0; i < 8; i++)
		begin
			mosi_out = sh[7];
			sclk_out = 1'b1;
			repeat (4) @(negedge clk_link);
			sh = {sh[6:0], miso_in};
			sclk_out = 1'b0;
			repeat (4) @(negedge clk_link);
		end
		rx_byte = sh;
		mosi_out = ~mosi_out;
	endtask
	task automatic release_sel;
		ss_n = 1'b1;
	endtask
endmodule
`default_nettype wire

/* File: verification/serial_port_tb.sv */
// Self-checking bench for the shared serial port block
`default_nettype none
module serial_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] A_CTL = serial_port_pkg::ADDR_SERIAL_PORT_CONTROL;
	localparam logic [7:0] A_DAT = serial_port_pkg::ADDR_SERIAL_PORT_DATA;
	localparam logic [7:0] A_TW  = serial_port_pkg::ADDR_TWOWIRE_CONTROL;
	logic                                clk_sys = 1'b0;
	logic                                clk_link = 1'b0;
	logic                                rst = 1'b1;
	serial_port_pkg::sfr_req_s           sfr_req = '0;
	serial_port_pkg::twowire_slave_evt_s twowire_evt = '0;
	logic                                pin_relocate_bit = 1'b0;
	logic                                tb_sda = 1'b1;
	logic                                tb_ss_n = 1'b1;
	logic [7:0]                          sfr_rdata;
	logic                                irq_serial, sclk_out, sclk_oe, sda_out, sda_oe;
	logic                                miso_out, miso_oe, far_sclk, far_mosi, far_ss_n, far_miso;
	int                                  n_mismatch = 0;
	int                                  n_tests = 0;
	int                                  n_edges = 0;
	realtime                             t0, t1;
	wire logic sclk_w = sclk_oe ? sclk_out : far_sclk;
	wire logic sda_w  = sda_oe ? sda_out : (far_ss_n ? tb_sda : far_mosi);
	wire logic miso_w = miso_oe ? miso_out : far_miso;
	wire logic ss_w   = far_ss_n & tb_ss_n;
	always #2.5 clk_sys = ~clk_sys;
	always #3 clk_link = ~clk_link;
	serial_port serial_port_inst (
		.clk_sys(clk_sys), .rst(rst), .clk_link(clk_link), .sfr_req(sfr_req),
		.sfr_rdata(sfr_rdata), .irq_serial(irq_serial), .twowire_evt(twowire_evt),
		.pin_relocate_bit(pin_relocate_bit), .ss_n_in(ss_w), .serial_clock_pin_in(sclk_w),
		.serial_clock_pin_out(sclk_out), .serial_clock_pin_oe(sclk_oe),
		.serial_data_pin_in(sda_w), .serial_data_pin_out(sda_out),
		.serial_data_pin_oe(sda_oe), .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe)
	);
	spi_far_end spi_far_end_inst (
		.clk_link(clk_link), .sclk_in(sclk_w), .mosi_in(sda_w), .miso_in(miso_w),
		.sclk_out(far_sclk), .mosi_out(far_mosi), .ss_n(far_ss_n), .miso_out(far_miso)
	);
	always @(posedge sclk_w)
	begin
		n_edges++;
		t0 = t1;
		t1 = $realtime;
	end
	task automatic final_report;
		$display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		sfr_req = '{wr: 1'b1, addr: a, wdata: d, default: '0};
		@(negedge clk_sys);
		sfr_req = '0;
	endtask
	task automatic bw(input logic [2:0] i, input logic v);
		@(negedge clk_sys);
		sfr_req = '{bit_wr: 1'b1, bit_idx: i, bit_val: v, addr: A_TW, default: '0};
		@(negedge clk_sys);
		sfr_req = '0;
		repeat (4) @(negedge clk_sys);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m, input string w);
		@(negedge clk_sys);
		sfr_req = '{rd: 1'b1, addr: a, default: '0};
		#1;
		chk(w, e & m, sfr_rdata & m);
		@(negedge clk_sys);
		sfr_req = '0;
	endtask
	task automatic ev(input logic gc, input logic v, input logic [1:0] c, input logic st, input logic e);
		@(negedge clk_sys);
		twowire_evt = '{gc, v, serial_port_pkg::twowire_irq_code_e'(c), st};
		#1;
		chk("tw_irq", {7'h0, e}, {7'h0, irq_serial});
		@(negedge clk_sys);
		twowire_evt = '0;
		repeat (4) @(negedge clk_sys);
	endtask
	task automatic wait_irq;
		int k;
		k = 0;
		while (irq_serial !== 1'b1 && k < 2000)
		begin
			@(negedge clk_sys);
			k++;
		end
		if (k >= 2000)
		begin
			n_mismatch++;
			$display("Error irq_wait expected 1 seen %b", irq_serial);
			final_report();
		end
	endtask
	initial
	begin
		repeat (12) @(negedge clk_sys);
		rst = 1'b0;
		rd(A_CTL, 8'h05, 8'hff, "ctl_rst");
		rd(A_DAT, 8'h00, 8'hff, "dat_rst");
		rd(A_TW, 8'h00, 8'hff, "tw_rst");
		rd(8'h80, 8'h00, 8'hff, "unmapped");
		for (int c = 0; c < 4; c++)
		begin
			tb_ss_n = (c != 3);
			spi_far_end_inst.load(8'h5a + 8'(c));
			wr(A_CTL, 8'h34 | 8'(c));
			n_edges = 0;
			wr(A_DAT, 8'hc1 ^ 8'(c));
			wait_irq();
			chk("edges", 8'h08, 8'(n_edges));
			chk("period", 8'h02 << c, 8'(int'((t1 - t0) / 5.0)));
			chk("mosi", 8'hc1 ^ 8'(c), spi_far_end_inst.rx_byte);
			rd(A_CTL, 8'h80, 8'hc0, "done");
			rd(A_DAT, 8'h5a + 8'(c), 8'hff, "miso");
			rd(A_CTL, 8'h00, 8'h80, "done_clr");
		end
		tb_ss_n = 1'b1;
		spi_far_end_inst.load(8'h96);
		wr(A_DAT, 8'h11);
		wr(A_DAT, 8'h22);
		wait_irq();
		rd(A_CTL, 8'hc0, 8'hc0, "write_collision_flag");
		rd(A_DAT, 8'h96, 8'hff, "rx_keep");
		chk("tx_keep", 8'h11, spi_far_end_inst.rx_byte);
		wr(A_CTL, 8'h24);
		rd(A_CTL, 8'h00, 8'hc0, "write_collision_flag_clr");
		wr(A_DAT, 8'h3c);
		spi_far_end_inst.run_master(8'hc3);
		wait_irq();
		spi_far_end_inst.release_sel();
		rd(A_DAT, 8'hc3, 8'hff, "slv_rx");
		chk("slv_tx", 8'h3c, spi_far_end_inst.rx_byte);
		wr(A_CTL, 8'h04);
		bw(3, 1'b1);
		rd(A_TW, 8'h08, 8'hff, "msel");
		bw(6, 1'b1);
		bw(7, 1'b1);
		chk("sda_drv", 8'h03, {6'h0, sda_oe, sda_out});
		bw(7, 1'b0);
		chk("sda_lo", 8'h02, {6'h0, sda_oe, sda_out});
		bw(6, 1'b0);
		chk("sda_in", 8'h00, {7'h0, sda_oe});
		bw(5, 1'b1);
		chk("scl_hi", 8'h03, {6'h0, sclk_oe, sclk_out});
		rd(A_TW, 8'h10, 8'h10, "mdi_hi");
		tb_sda = 1'b0;
		bw(5, 1'b0);
		rd(A_TW, 8'h10, 8'h10, "mdi_hold");
		bw(5, 1'b1);
		rd(A_TW, 8'h00, 8'h10, "mdi_lo");
		tb_sda = 1'b1;
		pin_relocate_bit = 1'b1;
		wr(A_CTL, 8'h34);
		bw(5, 1'b0);
		chk("scl_reloc", 8'h02, {6'h0, sclk_oe, sclk_out});
		pin_relocate_bit = 1'b0;
		wr(A_CTL, 8'h04);
		bw(3, 1'b0);
		for (int c = 0; c < 4; c++)
		begin
			ev(1'b0, 1'b1, 2'(c), 1'b0, 1'b1);
			rd(A_TW, 8'(c << 4), 8'h30, "cause");
			chk("tw_irq_end", 8'h00, {7'h0, irq_serial});
		end
		ev(1'b1, 1'b0, 2'h0, 1'b0, 1'b0);
		rd(A_TW, 8'h40, 8'h40, "gc_set");
		bw(6, 1'b0);
		rd(A_TW, 8'h00, 8'h40, "gc_clr");
		bw(7, 1'b1);
		ev(1'b0, 1'b0, 2'h0, 1'b1, 1'b1);
		rd(A_TW, 8'hb0, 8'hb0, "stop_cause");
		chk("stop_irq_end", 8'h00, {7'h0, irq_serial});
		final_report();
	end
endmodule
`default_nettype wire
